// >>> rtl/serial_programmer_command_decoder.sv
// Command decoder for the single-pin programming port
// Behaviour
// - Normal mode runs only the listed safe commands.
// - Flash mode runs all listed commands; protect bits gate flash.
// - Full protect blocks writes to main, page3.
// - Lower protect blocks writes lower half, page3.
// - Full protect blocks all main memory reads.
// - Lower protect blocks reads of lower half.
// - 00H returns revision, major byte first.
// - 02H returns status register byte.
// - 04H loads next byte into control register.
// - 05H returns control register byte.
// - 08H writes data bytes to consecutive controller registers.
// - 08H outside flash mode discards all bytes.
// - 09H returns bytes from consecutive controller registers.
// - 09H outside flash mode returns FFH bytes.
// - 0EH CRC read only in flash mode.
// - 1BH autobaud read in both modes.
// - F0H writes test register, both modes.
// - F1H reads test register, both modes.
// - Control bit 7 enters or leaves flash mode.
// - Bytes framed 8N1.5, LSB first, by framer.
`timescale 1ns/1ps
`include "prog_consts.svh"
module serial_programmer_command_decoder
   import prog_pkg::*;
#(
   parameter int AW = 16,
   parameter logic [15:0] PROGRAMMER_REVISION = 16'h0100 // Arbitrary value
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Received bytes from the framer
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   // Bytes to the framer
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   // Protection option bits
   input wire logic full_read_write_protect,
   input wire logic lower_half_protect,
   // Flash controller register port
   output logic fcr_we,
   output logic fcr_re,
   output logic [7:0] fcr_addr,
   output logic [7:0] fcr_wdata,
   input wire logic [7:0] fcr_rdata,
   // Flash memory port
   input wire logic info_area,
   input wire logic [1:0] info_page,
   output logic flash_we,
   output logic flash_re,
   output logic [AW-1:0] flash_addr,
   output logic [7:0] flash_wdata,
   input wire logic [7:0] flash_rdata,
   // CRC engine
   output logic crc_start,
   input wire logic crc_done,
   input wire logic [15:0] crc_value,
   // Autobaud value
   input wire logic [11:0] autobaud_value,
   // Mode and registers out
   output logic [7:0] programmer_control_reg,
   output logic [7:0] test_register,
   output logic flash_access_enable_bit
);
   dec_state_t state_r;
   logic [7:0] cmd_r;
   logic [2:0] argc_r;
   logic [2:0] argn;
   logic [AW-1:0] addr_r;
   logic [AW-1:0] wr_addr_r;
   logic [15:0] size_r;
   logic [15:0] left_r;
   logic [7:0] ctl_r;
   logic [7:0] test_r;
   logic [7:0] tx_data_r;
   logic tx_valid_r;
   logic second_r;
   logic [7:0] lo_byte_r;
   logic [7:0] hi_byte_r;
   logic allowed;
   logic wr_block;
   logic rd_block;
   logic fcr_last;
   logic fcr_load;
   logic fcr_step;
   logic [7:0] status;
   logic flash_mode;
   logic acc;
   logic [7:0] fcr_wdata_r;
   logic [7:0] flash_wdata_r;
   logic fcr_we_r;
   logic flash_we_r;

   // Mode flag and register views
   assign flash_mode = ctl_r[`CTL_FLASH_BIT];
   assign flash_access_enable_bit = flash_mode;
   assign programmer_control_reg = ctl_r;
   assign test_register = test_r;
   assign status = {flash_mode, lower_half_protect, full_read_write_protect, 5'h00};
   assign tx_valid = tx_valid_r;
   assign tx_data = tx_data_r;
   // Write strobes show the address their byte was taken at, not the advanced one
   assign fcr_addr = fcr_we_r ? wr_addr_r[7:0] : addr_r[7:0];
   assign flash_addr = flash_we_r ? wr_addr_r : addr_r;
   assign fcr_wdata = fcr_wdata_r;
   assign flash_wdata = flash_wdata_r;
   assign fcr_we = fcr_we_r;
   assign flash_we = flash_we_r;
   assign acc = tx_valid_r && tx_ready;

   // Legality and protection of the command in hand
   cmd_gate #(.AW(AW)) u_gate (
      .cmd(cmd_r),
      .flash_mode(flash_mode),
      .full_read_write_protect(full_read_write_protect),
      .lower_half_protect(lower_half_protect),
      .info_area(info_area),
      .info_page(info_page),
      .addr(addr_r),
      .allowed(allowed),
      .wr_block(wr_block),
      .rd_block(rd_block)
   );

   // Controller register transfers count in bytes of one size byte
   assign fcr_load = (state_r == ST_ARG) && rx_valid && (argc_r == argn - 3'd1);
   assign fcr_step = ((cmd_r == `CMD_FCR_WR) && state_r == ST_WDATA && rx_valid)
      || ((cmd_r == `CMD_FCR_RD) && state_r == ST_RDATA && acc);
   byte_count #(.W(8)) u_count (
      .clock(clock),
      .nrst(nrst),
      .load(fcr_load),
      .size(rx_data),
      .step(fcr_step),
      .last(fcr_last)
   );

   // Argument byte count per command
   always_comb begin
      case (cmd_r)
         `CMD_CTL_WR, `CMD_TEST_WR: argn = 3'd1;
         `CMD_FCR_WR, `CMD_FCR_RD: argn = 3'd3;
         `CMD_FL_WR, `CMD_FL_RD: argn = 3'd4;
         default: argn = 3'd0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer; withheld commands still swallow their arguments, reserved ones take none
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         cmd_r <= 8'h00;
         argc_r <= 3'd0;
         addr_r <= '0;
         size_r <= 16'h0000;
         left_r <= 16'h0000;
         second_r <= 1'b0;
         lo_byte_r <= 8'h00;
         hi_byte_r <= 8'h00;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (rx_valid) begin
                  cmd_r <= rx_data;
                  argc_r <= 3'd0;
                  second_r <= 1'b0;
                  state_r <= ST_ARG;
               end
            end
            ST_ARG: begin
               if (argn == 3'd0) begin
                  // No arguments: answer or finish at once
                  if (!allowed) begin
                     state_r <= ST_IDLE;
                  end else if (cmd_r == `CMD_CRC) begin
                     state_r <= ST_CRC_WAIT;
                  end else begin
                     state_r <= ST_SEND;
                  end
               end else if (rx_valid) begin
                  argc_r <= argc_r + 3'd1;
                  if (cmd_r == `CMD_FCR_WR || cmd_r == `CMD_FCR_RD) begin
                     // Filler byte is counted, then dropped
                     if (argc_r == 3'd1) begin
                        addr_r <= {{(AW-8){1'b0}}, rx_data};
                     end
                  end else begin
                     case (argc_r)
                        3'd0: addr_r[AW-1:8] <= rx_data[AW-9:0];
                        3'd1: addr_r[7:0] <= rx_data;
                        3'd2: size_r[15:8] <= rx_data;
                        default: size_r[7:0] <= rx_data;
                     endcase
                  end
                  if (argc_r == argn - 3'd1) begin
                     left_r <= {size_r[15:8], rx_data};
                     if (cmd_r == `CMD_FCR_WR || cmd_r == `CMD_FL_WR) begin
                        state_r <= ST_WDATA;
                     end else if (cmd_r == `CMD_FCR_RD) begin
                        state_r <= ST_RDATA;
                     end else if (cmd_r == `CMD_FL_RD) begin
                        state_r <= allowed ? ST_RDATA : ST_IDLE;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end
               end
            end
            ST_SEND: begin
               // Two-byte answers send high byte first
               if (acc) begin
                  if (!second_r && (cmd_r == `CMD_REV || cmd_r == `CMD_CRC
                        || cmd_r == `CMD_BAUD_RD)) begin
                     second_r <= 1'b1;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_WDATA: begin
               // Protection is judged on this edge, against the untouched address
               if (rx_valid) begin
                  addr_r <= addr_r + 1'b1;
                  left_r <= left_r - 16'h0001;
                  if ((cmd_r == `CMD_FCR_WR && fcr_last)
                        || (cmd_r == `CMD_FL_WR && left_r == 16'h0001)) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_RDATA: begin
               // Next byte is fetched only once the framer took this one
               if (acc) begin
                  addr_r <= addr_r + 1'b1;
                  left_r <= left_r - 16'h0001;
                  if ((cmd_r == `CMD_FCR_RD && fcr_last)
                        || (cmd_r == `CMD_FL_RD && left_r == 16'h0001)) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_CRC_WAIT: begin
               // Both bytes latched so a moving result cannot tear the answer
               if (crc_done) begin
                  lo_byte_r <= crc_value[7:0];
                  hi_byte_r <= crc_value[15:8];
                  state_r <= ST_SEND;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control and test registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctl_r <= `CTL_RESET;
         test_r <= `TEST_RESET;
      end else if (state_r == ST_ARG && rx_valid && argn == 3'd1) begin
         if (cmd_r == `CMD_CTL_WR) begin
            ctl_r <= rx_data;
         end else if (cmd_r == `CMD_TEST_WR) begin
            test_r <= rx_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write strobes; blocked or withheld bytes are simply dropped
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fcr_we_r <= 1'b0;
         flash_we_r <= 1'b0;
         fcr_wdata_r <= 8'h00;
         flash_wdata_r <= 8'h00;
         wr_addr_r <= '0;
      end else begin
         fcr_we_r <= 1'b0;
         flash_we_r <= 1'b0;
         if (state_r == ST_WDATA && rx_valid) begin
            // Keep the address this byte belongs to
            wr_addr_r <= addr_r;
            if (cmd_r == `CMD_FCR_WR) begin
               fcr_we_r <= flash_mode;
               fcr_wdata_r <= rx_data;
            end else begin
               flash_we_r <= allowed && !wr_block;
               flash_wdata_r <= rx_data;
            end
         end
      end
   end
   // A blocked byte still advances the address, so a partly protected
   // run lands its permitted bytes where the host expects them.

   ////////////////////////////////////////////////////////////////////////
   // Read strobes and answer byte
   assign fcr_re = state_r == ST_RDATA && cmd_r == `CMD_FCR_RD && flash_mode && !tx_valid_r;
   assign flash_re = state_r == ST_RDATA && cmd_r == `CMD_FL_RD && !rd_block && !tx_valid_r;
   assign crc_start = state_r == ST_ARG && cmd_r == `CMD_CRC && allowed;

   // Answer byte register; stands until the framer takes it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tx_valid_r <= 1'b0;
         tx_data_r <= 8'h00;
      end else if (acc) begin
         tx_valid_r <= 1'b0;
      end else if (!tx_valid_r) begin
         if (state_r == ST_SEND) begin
            tx_valid_r <= 1'b1;
            case (cmd_r)
               `CMD_REV: tx_data_r <= second_r ? PROGRAMMER_REVISION[7:0]
                  : PROGRAMMER_REVISION[15:8];
               `CMD_STAT_RD: tx_data_r <= status;
               `CMD_CTL_RD: tx_data_r <= ctl_r;
               `CMD_CRC: tx_data_r <= second_r ? lo_byte_r : hi_byte_r;
               `CMD_BAUD_RD: tx_data_r <= second_r ? autobaud_value[7:0]
                  : {4'h0, autobaud_value[11:8]};
               `CMD_TEST_RD: tx_data_r <= test_r;
               default: tx_data_r <= `FILL_BYTE;
            endcase
         end else if (state_r == ST_RDATA) begin
            tx_valid_r <= 1'b1;
            if (cmd_r == `CMD_FCR_RD) begin
               tx_data_r <= flash_mode ? fcr_rdata : `FILL_BYTE;
            end else begin
               tx_data_r <= rd_block ? `FILL_BYTE : flash_rdata;
            end
         end
      end
   end
   // Framing of each byte is done by the serial framer outside.
endmodule

// >>> rtl/prog_consts.svh
// Constants for the serial programmer command decoder
`ifndef PROG_CONSTS_SVH
`define PROG_CONSTS_SVH
`define CMD_REV 8'h00
`define CMD_STAT_RD 8'h02
`define CMD_CTL_WR 8'h04
`define CMD_CTL_RD 8'h05
`define CMD_FCR_WR 8'h08
`define CMD_FCR_RD 8'h09
`define CMD_FL_WR 8'h0A
`define CMD_FL_RD 8'h0B
`define CMD_CRC 8'h0E
`define CMD_BAUD_RD 8'h1B
`define CMD_TEST_WR 8'hF0
`define CMD_TEST_RD 8'hF1
`define CTL_FLASH_BIT 7
`define CTL_RESET 8'h00
`define TEST_RESET 8'h00
`define FILL_BYTE 8'hFF
`define INFO_PAGE3 2'h3
`endif

// >>> rtl/prog_pkg.sv
// Types shared by the command decoder files
package prog_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ARG, ST_SEND, ST_WDATA, ST_RDATA, ST_CRC_WAIT
   } dec_state_t;
endpackage

// >>> rtl/cmd_gate.sv
// Command legality and flash protection check
`timescale 1ns/1ps
`include "prog_consts.svh"
module cmd_gate #(
   parameter int AW = 16
) (
   // Command and mode
   input wire logic [7:0] cmd,
   input wire logic flash_mode,
   // Protection and target
   input wire logic full_read_write_protect,
   input wire logic lower_half_protect,
   input wire logic info_area,
   input wire logic [1:0] info_page,
   input wire logic [AW-1:0] addr,
   // Results
   output logic allowed,
   output logic wr_block,
   output logic rd_block
);
   logic lower;
   logic page3;
   // Lower half: top address bit clear
   assign lower = ~addr[AW-1];
   assign page3 = info_area && (info_page == `INFO_PAGE3);
   // Which codes run in normal mode
   always_comb begin
      case (cmd)
         `CMD_REV, `CMD_STAT_RD, `CMD_CTL_WR, `CMD_CTL_RD,
         `CMD_BAUD_RD, `CMD_TEST_WR, `CMD_TEST_RD: allowed = 1'b1;
         `CMD_FCR_WR, `CMD_FCR_RD, `CMD_FL_WR, `CMD_FL_RD,
         `CMD_CRC: allowed = flash_mode;
         default: allowed = 1'b0;
      endcase
   end
   // Write protect covers main memory and info page 3
   assign wr_block = (full_read_write_protect && (!info_area || page3))
      || (lower_half_protect && ((!info_area && lower) || page3));
   // Read protect covers main memory only
   assign rd_block = !info_area && (full_read_write_protect
      || (lower_half_protect && lower));
endmodule

// >>> rtl/byte_count.sv
// Transfer length counter; zero size means the maximum
`timescale 1ns/1ps
module byte_count #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Control
   input wire logic load,
   input wire logic [W-1:0] size,
   input wire logic step,
   // Status
   output logic last
);
   logic [W:0] left_r;
   // Zero size loads full range
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         left_r <= '0;
      end else if (load) begin
         left_r <= (size == '0) ? {1'b1, {W{1'b0}}} : {1'b0, size};
      end else if (step && left_r != '0) begin
         left_r <= left_r - 1'b1;
      end
   end
   assign last = (left_r == {{W{1'b0}}, 1'b1});
endmodule

// >>> tb/serial_programmer_command_decoder_properties.sv
// Port assertions for the command decoder
`timescale 1ns/1ps
module serial_programmer_command_decoder_properties #(
   parameter int AW = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Byte stream
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_ready,
   // Protection and target
   input wire logic full_read_write_protect,
   input wire logic lower_half_protect,
   input wire logic info_area,
   input wire logic [1:0] info_page,
   // Strobes
   input wire logic fcr_we,
   input wire logic flash_we,
   input wire logic flash_re,
   input wire logic [AW-1:0] flash_addr,
   input wire logic crc_start,
   // Registers
   input wire logic [7:0] programmer_control_reg,
   input wire logic [7:0] test_register,
   input wire logic flash_access_enable_bit
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   // Answer byte stands until taken
   a_tx_byte_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("answer byte changed before taken");
   a_mode_bit_tied: assert property ($changed(programmer_control_reg)
      |-> $past(rx_valid) && programmer_control_reg == $past(rx_data)
      && flash_access_enable_bit == programmer_control_reg[7])
      else $error("control register changed without its data byte");
   a_fcr_wr_mode: assert property (fcr_we |-> flash_access_enable_bit)
      else $error("controller write outside flash mode");
   a_flash_rd_mode: assert property (flash_re |-> flash_access_enable_bit)
      else $error("flash read outside flash mode");
   a_crc_mode_only: assert property (crc_start |-> flash_access_enable_bit)
      else $error("crc started outside flash mode");
   // Writes never pass protection; the strobe cycle shows the address the byte was taken at
   a_wr_full_prot: assert property (flash_we && full_read_write_protect
      |-> info_area && info_page != 2'h3)
      else $error("write passed full protection");
   a_wr_lower_prot: assert property (flash_we && lower_half_protect
      |-> (info_area ? info_page != 2'h3 : flash_addr[AW-1]))
      else $error("write passed lower half protection");
   a_test_reg_held: assert property (!rx_valid |=> $stable(test_register))
      else $error("test register changed without a byte");
endmodule

bind serial_programmer_command_decoder serial_programmer_command_decoder_properties #(.AW(AW))
   u_chk (.*);

// >>> tb/host_model.sv
// Host side stand-in that accepts answer bytes
`timescale 1ns/1ps
module host_model (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Answer bytes
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   // Stall control
   input wire logic slow
);
   logic [7:0] got[$];
   logic [1:0] div_r;
   ////////////////////////////////////////////////////////////////////////
   // Slow mode takes one byte in four cycles to stretch the hold time
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         div_r <= 2'h0;
         tx_ready <= 1'b0;
      end else begin
         div_r <= div_r + 2'h1;
         tx_ready <= !slow || div_r == 2'h3;
         if (tx_valid && tx_ready) got.push_back(tx_data);
      end
   end
endmodule

// >>> tb/serial_programmer_command_decoder_tb.sv
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module serial_programmer_command_decoder_tb;
   localparam int AW = 16;
   localparam logic [15:0] REV = 16'h0A5C; // Arbitrary value
   logic clock = 0, nrst = 0, rx_valid = 0, slow = 0, crc_done = 0, info_area = 0;
   logic full_read_write_protect = 0, lower_half_protect = 0;
   logic [1:0] info_page = 2'h0;
   logic [7:0] rx_data = 8'h00;
   logic [15:0] crc_value = 16'h4D2E;
   logic [11:0] autobaud_value = 12'hABC;
   logic [3:0] crc_dly = 4'h0;
   logic tx_valid, tx_ready, fcr_we, fcr_re, flash_we, flash_re, crc_start;
   logic flash_access_enable_bit;
   logic [7:0] tx_data, fcr_addr, fcr_wdata, flash_wdata, programmer_control_reg, test_register;
   logic [AW-1:0] flash_addr;
   logic [15:0] fcr_aw = 16'h0000;
   logic [AW+7:0] flash_aw = '0;
   // Read data follows the address and only shows while the read strobe stands
   wire [7:0] fcr_rdata = fcr_re ? (fcr_addr ^ 8'hE3) : 8'h00;
   wire [7:0] flash_rdata = flash_re ? (flash_addr[7:0] ^ 8'h86) : 8'h00;
   logic [7:0] bad [6] = '{8'h01, 8'h03, 8'h0E, 8'h1C, 8'hF2, 8'h0C};
   int n_mismatch = 0, total_checks = 0, fcr_cnt = 0, fw = 0, i;

   serial_programmer_command_decoder #(.AW(AW), .PROGRAMMER_REVISION(REV)) u_dut (.*);
   host_model u_host (.clock(clock), .nrst(nrst), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .slow(slow));

   always #12.5 clock = ~clock;
   // CRC engine stand-in answers a few cycles after start
   always @(negedge clock) begin
      crc_dly <= {crc_dly[2:0], crc_start};
      crc_done <= crc_dly[3];
   end
   // Strobe counters; the latest write address and data are kept
   always @(posedge clock) begin
      if (fcr_we === 1'b1) begin
         fcr_cnt++;
         fcr_aw <= {fcr_addr, fcr_wdata};
      end
      if (flash_we === 1'b1) begin
         fw++;
         flash_aw <= {flash_addr, flash_wdata};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One byte pulse, then a gap as a real framer would leave
   task send(input logic [7:0] b);
      @(negedge clock);
      rx_valid = 1;
      rx_data = b;
      @(negedge clock);
      rx_valid = 0;
      repeat (2) @(negedge clock);
   endtask
   task rx_exp(input logic [7:0] e);
      logic [7:0] b;
      for (int k = 0; k < 400 && u_host.got.size() == 0; k++) @(negedge clock);
      b = (u_host.got.size() > 0) ? u_host.got.pop_front() : 8'hXX;
      chk(b, e);
   endtask
   task quiet;
      repeat (40) @(negedge clock);
      chk(8'(u_host.got.size()), 8'h00);
   endtask
   // Flash access of one byte under given protection
   task prot(input logic [7:0] op, input logic [15:0] a, input logic f, l, ia,
      input logic [1:0] pg, input logic [7:0] e);
      int fw0;
      full_read_write_protect = f;
      lower_half_protect = l;
      info_area = ia;
      info_page = pg;
      fw0 = fw;
      send(op);
      send(a[15:8]);
      send(a[7:0]);
      send(8'h00);
      send(8'h01);
      if (op == 8'h0A) begin
         send(8'h55);
         quiet();
         chk(8'(fw - fw0), e);
         if (e != 8'h00) begin
            chk(flash_aw[15:8], a[7:0]);
            chk(flash_aw[7:0], 8'h55);
         end
      end else rx_exp(e);
   endtask
   task summarize;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      #2000000;
      n_mismatch++;
      summarize();
   end
   // Main sequence
   initial begin
      repeat (16) @(negedge clock);
      nrst = 1;
      chk(programmer_control_reg, 8'h00);
      chk(test_register, 8'h00);
      send(8'h00);
      rx_exp(REV[15:8]);
      rx_exp(REV[7:0]);
      lower_half_protect = 1;
      send(8'h02);
      rx_exp(8'h40);
      send(8'hF0);
      send(8'h5A);
      chk(test_register, 8'h5A);
      send(8'hF1);
      rx_exp(8'h5A);
      slow = 1;
      send(8'h1B);
      rx_exp(8'h0A);
      rx_exp(8'hBC);
      $display("normal mode reads done");
      // Withheld and reserved codes stay silent, except withheld 09H, which answers FFH bytes
      for (i = 0; i < 6; i++) begin
         send(bad[i]);
         quiet();
      end
      send(8'h08);
      send(8'hFF);
      send(8'h10);
      send(8'h02);
      send(8'h11);
      send(8'h22);
      chk(8'(fcr_cnt), 8'h00);
      send(8'h09);
      send(8'hFF);
      send(8'h10);
      send(8'h00);
      for (i = 0; i < 256; i++) rx_exp(8'hFF);
      quiet();
      slow = 0;
      $display("normal mode guards done");
      send(8'h04);
      send(8'h80);
      chk(flash_access_enable_bit, 1'b1);
      send(8'h05);
      rx_exp(8'h80);
      send(8'h02);
      rx_exp(8'hC0);
      send(8'h08);
      send(8'hFF);
      send(8'h20);
      send(8'h03);
      for (i = 0; i < 3; i++) send(8'hA0 + 8'(i));
      chk(8'(fcr_cnt), 8'h03);
      chk(fcr_aw[15:8], 8'h22);
      chk(fcr_aw[7:0], 8'hA2);
      send(8'h09);
      send(8'hFF);
      send(8'h20);
      send(8'h02);
      rx_exp(8'hC3);
      rx_exp(8'hC2);
      send(8'h0E);
      rx_exp(8'h4D);
      rx_exp(8'h2E);
      $display("flash mode commands done");
      prot(8'h0B, 16'h9010, 1, 0, 0, 2'h3, 8'hFF);
      prot(8'h0B, 16'h0010, 1, 0, 1, 2'h3, 8'h96);
      prot(8'h0B, 16'h0010, 0, 1, 0, 2'h3, 8'hFF);
      prot(8'h0B, 16'h9010, 0, 1, 0, 2'h3, 8'h96);
      prot(8'h0A, 16'h9010, 1, 0, 0, 2'h3, 8'h00);
      prot(8'h0A, 16'h0010, 1, 0, 1, 2'h3, 8'h00);
      prot(8'h0A, 16'h0010, 1, 0, 1, 2'h2, 8'h01);
      prot(8'h0A, 16'h0010, 0, 1, 0, 2'h3, 8'h00);
      prot(8'h0A, 16'h0010, 0, 1, 1, 2'h3, 8'h00);
      prot(8'h0A, 16'h9010, 0, 1, 0, 2'h3, 8'h01);
      $display("protection done");
      send(8'h04);
      send(8'h00);
      chk(flash_access_enable_bit, 1'b0);
      send(8'h0E);
      quiet();
      $display("mode exit done");
      summarize();
   end
endmodule
